// ### src/cwd_decoder.v
// How it works
// - Word one sits at index 8007h, word two at 8008h; 14 bits, blank ones.
// - Word one bit 13 enables the fail-safe clock monitor.
// - Word one bit 12 enables internal/external switchover.
// - Word one bit 11 low drives clock output on its pin.
// - Word one bits 10-9 pick brown-out mode: always, run, software, off.
// - Word one bit 7 low protects code; only bulk erase clears it.
// - Reset pin function from bit 6 unless low-voltage programming enabled.
// - Word one bit 5 low enables the power-up timer.
// - Word one bits 4-3 pick watchdog mode: always, run, software, off.
// - Word one bits 2-0 select the clock source.
// - Brown-out enable never turns on the power-up timer.
// - Word two bit 13 enables low-voltage programming; refuse 0 under LOW_VOLTAGE_PROGRAMMING_ENABLE entry.
// - Word two bit 12 low dedicates programming pins to the debugger; keep 1.
// - Word two bit 11 low enables low-power brown-out reset.
// - Word two bit 10 high picks the low brown-out trip point.
// - Word two bit 9 makes stack faults cause reset.
// - Word two bit 8 enables the clock multiplier.
// - Word two bit 7 picks three times, else four times.
// - Word two bit 6 picks USB slow divider eight, else four.
// - Word two bits 5-4 divide core clock by six, three, two, one.
// - Word two bits 1-0 set the self-write protected range.
// - Unimplemented bits read back as one.
// - Stack fault reset on push past sixteen or pop when empty; set flags.
// - Code protection zeroes word reads outside programming mode; programming-mode reads see the words.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`include "cwd_map.vh"
module cwd_decoder (
    // Clock, reset, enable
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // Device state from core logic
    input  wire        core_in_reset,
    input  wire        lvp_entry_active,
    input  wire        stack_push,
    input  wire        stack_pop,
    input  wire        software_brownout_enable,
    input  wire        software_watchdog_enable,
    input  wire        sleep_active,
    input  wire        port_pullup_bit,
    input  wire [12:0] self_write_addr,
    // Decoded controls
    output reg         clock_monitor_enable,
    output reg         int_ext_switchover_enable,
    output reg         clock_output_active,
    output reg         brownout_active,
    output reg         code_protect_active,
    output reg         reset_pin_is_clear,
    output reg         reset_pin_pullup,
    output reg         powerup_timer_active,
    output reg         watchdog_active,
    output reg  [2:0]  clock_source_select,
    output reg         debug_pins_dedicated,
    output reg         low_power_brownout_active,
    output reg         brownout_trip_low,
    output reg         stack_fault_reset_enable,
    output reg         multiplier_enable,
    output reg  [2:0]  multiplier_factor,
    output reg  [3:0]  usb_slow_clock_divider,
    output reg  [2:0]  core_clock_divider,
    output reg         self_write_blocked,
    output reg         stack_fault_reset,
    output reg         stack_overflow_flag,
    output reg         stack_underflow_flag
);

// ------------------------------------------------------------
// Register decode
// ------------------------------------------------------------
function [2:0] cwd_sel;
    input [31:0] addr;
    begin
        if (addr[1:0] != 2'h0 || addr[31:`CWD_ADDR_W] != 0)
            cwd_sel = 3'h0;
        else if (addr[17:2] == `CWD_IDX_WORD_ONE)
            cwd_sel = 3'h1;
        else if (addr[17:2] == `CWD_IDX_WORD_TWO)
            cwd_sel = 3'h2;
        else if (addr[17:2] == `CWD_IDX_CTRL)
            cwd_sel = 3'h3;
        else if (addr[17:2] == `CWD_IDX_STATUS)
            cwd_sel = 3'h4;
        else if (addr[17:2] == `CWD_IDX_PROG)
            cwd_sel = 3'h5;
        else
            cwd_sel = 3'h0;
    end
endfunction

function [1:0] cwd_mode_active;
    input [1:0] mode;
    input       sw_en;
    input       asleep;
    begin
        case (mode)
            `CWD_MODE_ALWAYS:   cwd_mode_active = 2'h1;
            `CWD_MODE_RUN_ONLY: cwd_mode_active = {1'b0, ~asleep};
            `CWD_MODE_SOFTWARE: cwd_mode_active = {1'b0, sw_en};
            default:            cwd_mode_active = 2'h0;
        endcase
    end
endfunction

reg  [13:0] word_one_q;
reg  [13:0] word_two_q;
reg  [13:0] shadow_one_q;
reg  [13:0] shadow_two_q;
reg         prog_mode_q;
reg  [4:0]  stack_depth_q;
reg         ovf_seen_q;
reg         unf_seen_q;
wire [2:0]  sel      = cwd_sel(paddr);
wire        access   = psel & penable & clk_en;
wire        wr       = access & pwrite;
wire        rd_hit   = access & ~pwrite;
wire        unmapped = (sel == 3'h0);
wire [13:0] one_rd   = word_one_q | (14'h1 << `CWD_W1_UNUSED);
wire [13:0] two_rd   = word_two_q | (14'h3 << `CWD_W2_UNUSED_LO);
wire        ext_block = ~shadow_one_q[`CWD_W1_PROTECT_N] & ~prog_mode_q;

assign pready  = 1'b1;
assign pslverr = psel & penable & unmapped;

// ------------------------------------------------------------
// Two-flop synchronisers for inputs from other domains
// ------------------------------------------------------------
// Bit 0 is low-voltage entry, bit 1 is sleep; only stage two is read
wire [1:0]  async_in = {sleep_active, lvp_entry_active};
reg  [1:0]  sync_a_q;
reg  [1:0]  sync_b_q;
genvar      g;

generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync_a_q[g] <= 1'b0;
                sync_b_q[g] <= 1'b0;
            end else if (clk_en) begin
                sync_a_q[g] <= async_in[g];
                sync_b_q[g] <= sync_a_q[g];
            end
        end
    end
endgenerate

// ------------------------------------------------------------
// Programming mode latch
// ------------------------------------------------------------
// External access is modelled as this mode; it may be left at any time
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prog_mode_q <= 1'b0;
    end else if (wr && sel == 3'h5) begin
        prog_mode_q <= pwdata[0];
    end
end

// ------------------------------------------------------------
// Configuration memory, word writes only in programming mode
// ------------------------------------------------------------
// Programming writes can only clear bits (flash style); erase restores ones.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        word_one_q  <= `CWD_BLANK_WORD;
        word_two_q  <= `CWD_BLANK_WORD;
    end else if (clk_en) begin
        if (wr && sel == 3'h5 && pwdata[1]) begin
            word_one_q <= `CWD_BLANK_WORD;
            word_two_q <= `CWD_BLANK_WORD;
        end
        if (wr && prog_mode_q && sel == 3'h1)
            word_one_q <= word_one_q & pwdata[13:0];
        if (wr && prog_mode_q && sel == 3'h2) begin
            word_two_q <= word_two_q & pwdata[13:0];
            if (sync_b_q[0])
                word_two_q[`CWD_W2_LVP] <= word_two_q[`CWD_W2_LVP];
        end
    end
end

// ------------------------------------------------------------
// Read mux
// ------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
    end else if (rd_hit) begin
        case (sel)
            3'h1:    prdata <= ext_block ? 32'h0 : {18'h0, one_rd};
            3'h2:    prdata <= ext_block ? 32'h0 : {18'h0, two_rd};
            3'h3:    prdata <= {18'h0, shadow_one_q};
            3'h4:    prdata <= {25'h0, stack_depth_q, unf_seen_q, ovf_seen_q};
            3'h5:    prdata <= {31'h0, prog_mode_q};
            default: prdata <= 32'h0;
        endcase
    end
end

// ------------------------------------------------------------
// Sample at reset, hold while running
// ------------------------------------------------------------
// Shadow words never change mid-run; new words take effect at next reset.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        shadow_one_q <= `CWD_BLANK_WORD;
        shadow_two_q <= `CWD_BLANK_WORD;
    end else if (clk_en && core_in_reset) begin
        shadow_one_q <= one_rd;
        shadow_two_q <= two_rd;
    end
end

// ------------------------------------------------------------
// Stack depth tracking
// ------------------------------------------------------------
wire overflow  = stack_push & ~stack_pop & (stack_depth_q == `CWD_STACK_DEPTH);
wire underflow = stack_pop & ~stack_push & (stack_depth_q == 5'h0);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stack_depth_q <= 5'h0;
        ovf_seen_q    <= 1'b0;
        unf_seen_q    <= 1'b0;
    end else if (clk_en) begin
        if (core_in_reset)
            stack_depth_q <= 5'h0;
        else if (overflow | underflow)
            stack_depth_q <= stack_depth_q;
        else if (stack_push & ~stack_pop)
            stack_depth_q <= stack_depth_q + 5'h1;
        else if (stack_pop & ~stack_push)
            stack_depth_q <= stack_depth_q - 5'h1;
        // Set wins over software clear
        if (overflow)
            ovf_seen_q <= 1'b1;
        else if (wr && sel == 3'h4 && pwdata[0])
            ovf_seen_q <= 1'b0;
        if (underflow)
            unf_seen_q <= 1'b1;
        else if (wr && sel == 3'h4 && pwdata[1])
            unf_seen_q <= 1'b0;
    end
end

// ------------------------------------------------------------
// Stack fault reset pulse
// ------------------------------------------------------------
// One cycle wide; the reset controller stretches it as it needs
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stack_fault_reset <= 1'b0;
    end else if (clk_en) begin
        stack_fault_reset <= (overflow | underflow)
                           & shadow_two_q[`CWD_W2_STACK_RST];
    end
end

// ------------------------------------------------------------
// Stack fault flags toward the power control register
// ------------------------------------------------------------
// Flags mirror the sticky status bits; software clears them there
always @* begin
    stack_overflow_flag  = ovf_seen_q;
    stack_underflow_flag = unf_seen_q;
end

// ------------------------------------------------------------
// Decoded controls
// ------------------------------------------------------------
wire [1:0] bor_mode = shadow_one_q[`CWD_W1_BOR_HI:`CWD_W1_BOR_LO];
wire [1:0] wdt_mode = shadow_one_q[`CWD_W1_WDT_HI:`CWD_W1_WDT_LO];
wire [1:0] bor_act  = cwd_mode_active(bor_mode, software_brownout_enable, sync_b_q[1]);
wire [1:0] wdt_act  = cwd_mode_active(wdt_mode, software_watchdog_enable, sync_b_q[1]);
wire       lvp_on   = shadow_two_q[`CWD_W2_LVP];
wire [1:0] self_write_protect_range      = shadow_two_q[`CWD_W2_WRT_HI:`CWD_W2_WRT_LO];
reg        wrt_hit;

// ------------------------------------------------------------
// Self-write range compare and word one controls
// ------------------------------------------------------------
// Self-write range compare is combinational so the check follows the address
always @* begin
    case (self_write_protect_range)
        2'h2:    wrt_hit = (self_write_addr <= `CWD_WRT_TOP_HALF);
        2'h1:    wrt_hit = (self_write_addr <= `CWD_WRT_TOP_MID);
        2'h0:    wrt_hit = (self_write_addr <= `CWD_WRT_TOP_ALL);
        default: wrt_hit = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        clock_monitor_enable      <= 1'b1;
        int_ext_switchover_enable <= 1'b1;
        clock_output_active       <= 1'b0;
        brownout_active           <= 1'b1;
        code_protect_active       <= 1'b0;
        // Blank decode: each output as an all-ones word decodes, as an erased part would start
        reset_pin_is_clear        <= 1'b1;
        reset_pin_pullup          <= 1'b1;
        powerup_timer_active      <= 1'b0;
        watchdog_active           <= 1'b1;
        clock_source_select       <= 3'h7;
    end else if (clk_en) begin
        clock_monitor_enable      <= shadow_one_q[`CWD_W1_MONITOR];
        int_ext_switchover_enable <= shadow_one_q[`CWD_W1_SWITCHOVER];
        clock_output_active       <= ~shadow_one_q[`CWD_W1_CLOCK_OUTPUT_PIN_N];
        brownout_active           <= bor_act[0];
        code_protect_active       <= ~shadow_one_q[`CWD_W1_PROTECT_N];
        // Low-voltage programming keeps the pin as master clear
        reset_pin_is_clear        <= lvp_on | shadow_one_q[`CWD_W1_RESET_PIN];
        reset_pin_pullup          <= (lvp_on | shadow_one_q[`CWD_W1_RESET_PIN])
                                   ? 1'b1 : port_pullup_bit;
        powerup_timer_active      <= ~shadow_one_q[`CWD_W1_POWERUP_TIMER_N];
        watchdog_active           <= wdt_act[0];
        clock_source_select       <= shadow_one_q[`CWD_W1_OSC_HI:`CWD_W1_OSC_LO];
    end
end

// ------------------------------------------------------------
// Word two controls
// ------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        low_power_brownout_active <= 1'b0;
        brownout_trip_low         <= 1'b1;
        stack_fault_reset_enable  <= 1'b1;
        multiplier_enable         <= 1'b1;
        multiplier_factor         <= 3'h3;
        usb_slow_clock_divider    <= 4'h8;
        core_clock_divider        <= 3'h6;
    end else if (clk_en) begin
        low_power_brownout_active <= ~shadow_two_q[`CWD_W2_LOW_POWER_BROWNOUT_ENABLE_N_N];
        brownout_trip_low         <= shadow_two_q[`CWD_W2_BROWNOUT_TRIP_SELECT];
        stack_fault_reset_enable  <= shadow_two_q[`CWD_W2_STACK_RST];
        multiplier_enable         <= shadow_two_q[`CWD_W2_PLL_EN];
        multiplier_factor         <= shadow_two_q[`CWD_W2_PLL_MULT] ? 3'h3 : 3'h4;
        usb_slow_clock_divider    <= shadow_two_q[`CWD_W2_USB_DIV] ? 4'h8 : 4'h4;
        case (shadow_two_q[`CWD_W2_CPU_HI:`CWD_W2_CPU_LO])
            2'h3:    core_clock_divider <= 3'h6;
            2'h2:    core_clock_divider <= 3'h3;
            2'h1:    core_clock_divider <= 3'h2;
            default: core_clock_divider <= 3'h1;
        endcase
    end
end

// ------------------------------------------------------------
// Debug and self-write protection
// ------------------------------------------------------------
// The range check tracks the address each cycle; only the range is frozen
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        debug_pins_dedicated      <= 1'b0;
        self_write_blocked        <= 1'b0;
    end else if (clk_en) begin
        debug_pins_dedicated      <= ~shadow_two_q[`CWD_W2_DEBUG];
        self_write_blocked        <= wrt_hit;
    end
end

endmodule // cwd_decoder

// ### src/cwd_map.vh
`ifndef CWD_MAP_VH
`define CWD_MAP_VH
// ------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ------------------------------------------------------------
`define CWD_IDX_WORD_ONE      16'h8007
`define CWD_IDX_WORD_TWO      16'h8008
`define CWD_IDX_CTRL          16'h8009
`define CWD_IDX_STATUS        16'h800a
`define CWD_IDX_PROG          16'h800b
`define CWD_ADDR_W            18
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CWD_BLANK_WORD        14'h3fff
// ------------------------------------------------------------
// Word one fields
// ------------------------------------------------------------
`define CWD_W1_MONITOR        13
`define CWD_W1_SWITCHOVER     12
`define CWD_W1_CLOCK_OUTPUT_PIN_N       11
`define CWD_W1_BOR_HI         10
`define CWD_W1_BOR_LO         9
`define CWD_W1_UNUSED         8
`define CWD_W1_PROTECT_N      7
`define CWD_W1_RESET_PIN      6
`define CWD_W1_POWERUP_TIMER_N         5
`define CWD_W1_WDT_HI         4
`define CWD_W1_WDT_LO         3
`define CWD_W1_OSC_HI         2
`define CWD_W1_OSC_LO         0
// ------------------------------------------------------------
// Word two fields
// ------------------------------------------------------------
`define CWD_W2_LVP            13
`define CWD_W2_DEBUG          12
`define CWD_W2_LOW_POWER_BROWNOUT_ENABLE_N_N        11
`define CWD_W2_BROWNOUT_TRIP_SELECT           10
`define CWD_W2_STACK_RST      9
`define CWD_W2_PLL_EN         8
`define CWD_W2_PLL_MULT       7
`define CWD_W2_USB_DIV        6
`define CWD_W2_CPU_HI         5
`define CWD_W2_CPU_LO         4
`define CWD_W2_UNUSED_HI      3
`define CWD_W2_UNUSED_LO      2
`define CWD_W2_WRT_HI         1
`define CWD_W2_WRT_LO         0
// ------------------------------------------------------------
// Encodings
// ------------------------------------------------------------
`define CWD_MODE_ALWAYS       2'h3
`define CWD_MODE_RUN_ONLY     2'h2
`define CWD_MODE_SOFTWARE     2'h1
`define CWD_MODE_OFF          2'h0
`define CWD_STACK_DEPTH       5'h10
`define CWD_WRT_TOP_HALF      13'h01ff
`define CWD_WRT_TOP_MID       13'h0fff
`define CWD_WRT_TOP_ALL       13'h1fff
`endif

// ### testbench/cwd_properties.sv
`timescale 1ns/1ns
module cwd_properties (
    // Clock and reset
    input logic        pclk,
    input logic        presetn,
    input logic        clk_en,
    // Register bus
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] prdata,
    input logic        pslverr,
    // Core side
    input logic        core_in_reset,
    input logic        stack_push,
    input logic        stack_pop,
    input logic        stack_fault_reset,
    input logic        stack_fault_reset_enable,
    input logic        code_protect_active,
    input logic        powerup_timer_active,
    input logic [2:0]  clock_source_select,
    input logic [2:0]  multiplier_factor,
    input logic [3:0]  usb_slow_clock_divider,
    input logic [2:0]  core_clock_divider
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic hit;
    logic acc;
    assign hit = paddr inside {32'h2001c, 32'h20020, 32'h20024, 32'h20028, 32'h2002c};
    assign acc = psel && penable && clk_en;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_unmapped_err: assert property (
        psel && penable && !hit |-> pslverr) else $error("unmapped access without error");
    a_mapped_ok: assert property (
        psel && penable && hit |-> !pslverr) else $error("mapped access flagged");
    a_unmapped_zero: assert property (
        acc && !pwrite && !hit |=> prdata == 32'h0) else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !(acc && !pwrite) |=> $stable(prdata)) else $error("read data moved");
    // Three quiet cycles cover the shadow load plus the output stage
    a_controls_held: assert property (
        !core_in_reset && !$past(core_in_reset) && !$past(core_in_reset, 2) |->
        $stable({code_protect_active, powerup_timer_active, clock_source_select,
                 multiplier_factor, usb_slow_clock_divider, core_clock_divider}))
        else $error("control changed while running");
    a_fault_pulse: assert property (
        stack_fault_reset && !stack_push && !stack_pop |=> !stack_fault_reset)
        else $error("fault reset longer than one cycle");
    a_fault_cause: assert property (
        $rose(stack_fault_reset) |-> $past(stack_push) || $past(stack_pop))
        else $error("fault reset without stack action");
    a_fault_gated: assert property (
        stack_fault_reset |-> stack_fault_reset_enable) else $error("fault reset while disabled");
    a_ratio_codes: assert property (
        multiplier_factor inside {3'd3, 3'd4} && usb_slow_clock_divider inside {4'd4, 4'd8}
        && core_clock_divider inside {3'd1, 3'd2, 3'd3, 3'd6}) else $error("bad ratio code");
endmodule // cwd_properties

bind cwd_decoder cwd_properties chk_u (.*);

// ### testbench/cwd_prog_tool.sv
`timescale 1ns/1ns
module cwd_prog_tool (
    // Clock
    input  logic        pclk,
    // Bus toward the block
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input  logic        pready,
    input  logic [31:0] prdata,
    input  logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    // ------------------------------------------------------------
    // One transfer; words go out as the caller built them, so the
    // debug bit stays at 1 unless a test clears it on purpose
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
            @(negedge pclk);
        end
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not look like the last request
        paddr <= ~a;
        pwdata <= ~d;
        @(negedge pclk);
        q = prdata;
    endtask
endmodule // cwd_prog_tool

// ### testbench/testbench.sv
`timescale 1ns/1ns
`include "cwd_map.vh"
module testbench;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, q;
    logic core_in_reset, lvp_entry_active, stack_push, stack_pop, sleep_active;
    logic software_brownout_enable, software_watchdog_enable, port_pullup_bit;
    logic [12:0] self_write_addr;
    logic clock_monitor_enable, int_ext_switchover_enable, clock_output_active;
    logic brownout_active, code_protect_active, reset_pin_is_clear, reset_pin_pullup;
    logic powerup_timer_active, watchdog_active, debug_pins_dedicated, brownout_trip_low;
    logic low_power_brownout_active, stack_fault_reset_enable, multiplier_enable;
    logic self_write_blocked, stack_fault_reset, stack_overflow_flag, stack_underflow_flag;
    logic [2:0] clock_source_select, multiplier_factor, core_clock_divider;
    logic [3:0] usb_slow_clock_divider;
    logic [13:0] w1, w2;
    integer error_cnt = 0, num_checks = 0, faults = 0, i;
    localparam logic [31:0] A_W1 = {14'h0, `CWD_IDX_WORD_ONE, 2'b00};
    localparam logic [31:0] A_W2 = {14'h0, `CWD_IDX_WORD_TWO, 2'b00};
    localparam logic [31:0] A_ST = {14'h0, `CWD_IDX_STATUS, 2'b00};
    localparam logic [31:0] A_PG = {14'h0, `CWD_IDX_PROG, 2'b00};

    cwd_decoder dut_u (.*);
    cwd_prog_tool prog_u (.*);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (stack_fault_reset === 1'b1) faults <= faults + 1;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task cyc(input int n); repeat (n) @(posedge pclk); endtask
    task wr(input logic [31:0] a, input logic [31:0] d); prog_u.xfer(1'b1, a, d, q, err); endtask
    task rd(input logic [31:0] a); prog_u.xfer(1'b0, a, 32'h0, q, err); endtask
    task stk(input logic push, input int n);
        repeat (n) begin
            @(posedge pclk);
            stack_push <= push;
            stack_pop <= !push;
            @(posedge pclk);
            stack_push <= 1'b0;
            stack_pop <= 1'b0;
        end
        cyc(2);
    endtask
    task hard_reset; @(posedge pclk); presetn <= 1'b0; cyc(2); presetn <= 1'b1; cyc(1); endtask
    function logic mode_on(input logic [1:0] m, input logic s, input logic e);
        return m == 2'h3 || (m == 2'h2 && !s) || (m == 2'h1 && e);
    endfunction
    task check_ctl(input logic [13:0] a, input logic [13:0] b);
        check({clock_monitor_enable, int_ext_switchover_enable, clock_output_active,
               code_protect_active, clock_source_select},
              {a[13], a[12], !a[11], !a[7], a[2:0]});
        check({brownout_active, watchdog_active, powerup_timer_active},
              {mode_on(a[10:9], sleep_active, software_brownout_enable),
               mode_on(a[4:3], sleep_active, software_watchdog_enable), !a[5]});
        if (!b[13]) check({reset_pin_is_clear, reset_pin_pullup}, {a[6], a[6] | port_pullup_bit});
        check({debug_pins_dedicated, low_power_brownout_active, brownout_trip_low,
               stack_fault_reset_enable, multiplier_enable},
              {!b[12], !b[11], b[10], b[9], b[8]});
        check({multiplier_factor, usb_slow_clock_divider, core_clock_divider},
              {b[7] ? 3'd3 : 3'd4, b[6] ? 4'd8 : 4'd4,
               b[5:4] == 2'h3 ? 3'd6 : {1'b0, b[5:4]} + 3'd1});
        check(self_write_blocked, b[1:0] != 2'h3 && self_write_addr <= (b[1:0] == 2'h2 ?
              13'h01ff : b[1:0] == 2'h1 ? 13'h0fff : 13'h1fff));
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, stack_push, stack_pop, core_in_reset, lvp_entry_active} = 5'h0;
        {sleep_active, software_brownout_enable, software_watchdog_enable} = 3'h0;
        port_pullup_bit = 1'b0;
        self_write_addr = 13'h0;
        clk_en = 1'b1;
        cyc(2);
        presetn <= 1'b1;
        cyc(1);
        rd(A_W1); check(q, 32'h3fff);
        rd(A_W2); check(q, 32'h3fff);
        check_ctl(14'h3fff, 14'h3fff);
        // Sixteen pushes fit; the seventeenth overflows
        stk(1'b1, 16); rd(A_ST); check(q, 32'h40);
        stk(1'b1, 1); rd(A_ST); check(q[1:0], 2'b01); check(faults, 1);
        check(stack_overflow_flag, 1'b1);
        wr(A_ST, 32'h3); rd(A_ST); check(q[1:0], 2'b00);
        check(stack_overflow_flag, 1'b0);
        hard_reset;
        stk(1'b0, 1); rd(A_ST); check(q[1:0], 2'b10); check(faults, 2);
        check(stack_underflow_flag, 1'b1);
        for (i = 0; i < 8; i++) begin
            w1 = {i[0], i[1], i[2], i[1:0], 1'b0, 1'b1, i[0], i[1], ~i[1:0], i[2:0]};
            w2 = {1'b0, i[2], i[0], i[1], i[2], i[0], i[1], i[2], i[1:0], 2'b00, i[2:1]};
            sleep_active <= i[2];
            software_brownout_enable <= i[1] ^ i[0];
            software_watchdog_enable <= i[2];
            port_pullup_bit <= i[1];
            self_write_addr <= i[0] ? 13'h1000 : 13'h01ff;
            wr(A_PG, 32'h3); wr(A_W1, {18'h0, w1}); wr(A_W2, {18'h0, w2}); wr(A_PG, 32'h0);
            rd(A_W1); check(q, {18'h0, w1 | 14'h0100});
            rd(A_W2); check(q, {18'h0, w2 | 14'h000c});
            core_in_reset <= 1'b1; cyc(3); core_in_reset <= 1'b0; cyc(4);
            check_ctl(w1, w2);
            // Erasing the words must not reach the running controls
            wr(A_PG, 32'h3); wr(A_PG, 32'h0); cyc(3);
            check_ctl(w1, w2);
        end
        wr(A_PG, 32'h3); wr(A_W1, 32'h3f7f); wr(A_PG, 32'h0);
        core_in_reset <= 1'b1; cyc(3); core_in_reset <= 1'b0; cyc(4);
        check(code_protect_active, 1'b1);
        rd(A_W1); check(q, 32'h0);
        wr(A_PG, 32'h1); wr(A_W1, 32'h3fff); rd(A_W1); check(q, 32'h3f7f);
        wr(A_PG, 32'h3); rd(A_W1); check(q, 32'h3fff);
        lvp_entry_active <= 1'b1; cyc(3);
        wr(A_W2, 32'h1fff); rd(A_W2); check(q, 32'h3fff);
        lvp_entry_active <= 1'b0; cyc(3);
        wr(A_W2, 32'h1fff); rd(A_W2); check(q, 32'h1fff);
        // Enable low freezes the stack depth
        clk_en <= 1'b0; stk(1'b1, 1); clk_en <= 1'b1;
        rd(A_ST); check(q[6:2], 5'h0);
        rd(32'h20030); check(err, 1'b1); check(q, 32'h0);
        report_and_stop;
    end
    initial begin
        #400000;
        error_cnt++;
        report_and_stop;
    end
endmodule // testbench
